// file: hdl/audio_input_routing.sv
// Purpose: APB control bytes decoded into input, mix and direct path switch enables
// Assumes: Single 10 MHz clock; host keeps to the supported codes
// Notes:   Switch and direct outputs lag the control registers by one clock; the other outputs follow them directly
//
// How it works
// - Control byte 0 bits 7..5 pick one of eight input layouts.
// - Bits 2..0 of byte 0 and byte 1 pick main and second source.
// - Layout 0 codes 0-3 pick quasi pairs 1-4; layout 4 code 3 full diff.
// - Layout 1: se1, se3, quasi 3, quasi 4, se2; layout 7 code 3 full diff.
// - Layout 2: se1, se3, quasi 3, -, se2, se4, se5.
// - Layout 3: se1, se3, quasi 3, mono pair, se2.
// - Layout 5: quasi 1-3 on codes 0-2, se4 and se5 on codes 5-6.
// - Layout 6: se3, quasi 3, full diff, se2 on 1-4, mono 3 on 7.
// - Bit 3 of byte 0 or 1 picks mono pair 1 or 2.
// - A control bit sets input gain to 0 dB or 3 dB.
// - Byte 1 bits 7..5 enable direct paths bypassing filters and volume.
// - Direct: quasi 2 to front, quasi 3 to rear, pair 4 plus to second.
// - Mix source goes to front and rear independently via 0..-31 dB attenuator.
// - Mix byte 2 bits 2..0: code 6 beep, 7 silence everywhere.
// - Layouts 1 and 7: mix codes 0-2 pick se1, se2, se3.
// - Layout 2: mix codes 0-4 pick se1 to se5.
// - Layout 3: mix se1-se3, code 3 mono 1, code 5 mono 2.
// - Layout 5: mix codes 3 and 4 pick se4 and se5 only.
// - Beep reaches the mixer from one clock after the offset detector turns off until one clock after it turns on.
// - Byte 3 bit 7 picks offset detector or level meter, never both.
`timescale 1ns/1ps
`default_nettype none
`include "audio_route_defs.svh"

module audio_input_routing
   import audio_route_pkg::*;
#(
   parameter int ADDR_W = 12
)(
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output var  logic [31:0]       prdata,
   output var  logic              pready,
   output var  logic              pslverr,
   // Source selectors
   output var  src_sw_s           main_switch,
   output var  src_sw_s           second_switch,
   output var  logic              input_gain_3db,
   // Mixer
   output var  mix_sw_s           mix_switch,
   output var  logic [4:0]        mix_atten,
   output var  logic              mix_front_en,
   output var  logic              mix_rear_en,
   // Direct path and pin function
   output var  direct_s           direct_route,
   output var  logic              offset_det_en,
   output var  logic              level_meter_en
);

   if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must lie between 5 and 32");
   end

   state_s  st_q;
   state_s  st_d;
   src_sw_s main_dec;
   src_sw_s sec_dec;
   logic    main_legal;
   logic    sec_legal;
   logic    acc_wr;
   logic    acc_any;
   logic    hit;

   // Main and second selectors share one layout
   source_decode u_main_dec (
      .layout    (st_q.ctrl0[`LAYOUT_HI:`LAYOUT_LO]),
      .code      (st_q.ctrl0[`CODE_HI:`CODE_LO]),
      .mono_pick (st_q.ctrl0[`MONO_BIT]),
      .sw        (main_dec),
      .legal     (main_legal)
   );

   source_decode u_sec_dec (
      .layout    (st_q.ctrl0[`LAYOUT_HI:`LAYOUT_LO]),
      .code      (st_q.ctrl1[`CODE_HI:`CODE_LO]),
      .mono_pick (st_q.ctrl1[`MONO_BIT]),
      .sw        (sec_dec),
      .legal     (sec_legal)
   );

   function automatic mix_sw_s mix_decode(input code_t layout, input code_t code, input logic meter);
      mix_sw_s m;
      m = '0;
      if (code == `MIX_BEEP) begin
         // Beep shares the detector input pin
         m.beep = meter;
      end else if (code != `MIX_MUTE) begin
         unique case (layout)
            3'h0, 3'h4: ;
            3'h1, 3'h7: begin
               case (code)
                  3'h0: m.se1 = 1'b1;
                  3'h1: m.se2 = 1'b1;
                  3'h2: m.se3 = 1'b1;
                  default: ;
               endcase
            end
            3'h2: begin
               case (code)
                  3'h0: m.se1 = 1'b1;
                  3'h1: m.se2 = 1'b1;
                  3'h2: m.se3 = 1'b1;
                  3'h3: m.se4 = 1'b1;
                  3'h4: m.se5 = 1'b1;
                  default: ;
               endcase
            end
            3'h3: begin
               case (code)
                  3'h0: m.se1 = 1'b1;
                  3'h1: m.se2 = 1'b1;
                  3'h2: m.se3 = 1'b1;
                  3'h3: m.md1 = 1'b1;
                  3'h5: m.md2 = 1'b1;
                  default: ;
               endcase
            end
            3'h5: begin
               case (code)
                  3'h3: m.se4 = 1'b1;
                  3'h4: m.se5 = 1'b1;
                  default: ;
               endcase
            end
            3'h6: begin
               case (code)
                  3'h0: m.md3 = 1'b1;
                  3'h1: m.se2 = 1'b1;
                  3'h2: m.se3 = 1'b1;
                  default: ;
               endcase
            end
         endcase
      end
      return m;
   endfunction : mix_decode

   function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [4:0] off);
      return a == ADDR_W'(off);
   endfunction : addr_is

   assign acc_any = psel & penable;
   assign acc_wr  = acc_any & pwrite & pstrb[0];
   assign hit     = addr_is(paddr, `OFF_CTRL0) | addr_is(paddr, `OFF_CTRL1)
                  | addr_is(paddr, `OFF_CTRL2) | addr_is(paddr, `OFF_CTRL3)
                  | addr_is(paddr, `OFF_STAT_MAIN) | addr_is(paddr, `OFF_STAT_SEC)
                  | addr_is(paddr, `OFF_STAT_MIX);

   // Zero wait states; read data is loaded during setup
   assign pready  = 1'b1;
   assign pslverr = acc_any & ~hit;

   always_comb begin
      st_d = st_q;
      if (acc_wr) begin
         if (addr_is(paddr, `OFF_CTRL0)) st_d.ctrl0 = pwdata[7:0];
         if (addr_is(paddr, `OFF_CTRL1)) st_d.ctrl1 = pwdata[7:0];
         if (addr_is(paddr, `OFF_CTRL2)) st_d.ctrl2 = pwdata[7:0];
         if (addr_is(paddr, `OFF_CTRL3)) st_d.ctrl3 = pwdata[7:0];
      end
      st_d.main_sw = main_dec;
      st_d.main_ok = main_legal;
      st_d.sec_sw  = sec_dec;
      st_d.sec_ok  = sec_legal;
      st_d.mix_sw  = mix_decode(st_q.ctrl0[`LAYOUT_HI:`LAYOUT_LO], st_q.ctrl2[`CODE_HI:`CODE_LO],
                                st_q.ctrl3[`METER_BIT]);
      st_d.mix_ok  = |st_d.mix_sw | (st_q.ctrl2[`CODE_HI:`CODE_LO] == `MIX_MUTE);
      st_d.direct.front_qd2   = st_q.ctrl1[`DIR_FRONT_BIT];
      st_d.direct.rear_qd3    = st_q.ctrl1[`DIR_REAR_BIT];
      st_d.direct.second_qd4p = st_q.ctrl1[`DIR_SECOND_BIT];
      // Second output would mix two sources in these layouts
      st_d.split = st_q.ctrl1[`DIR_SECOND_BIT]
                 & (st_q.ctrl0[`LAYOUT_HI:`LAYOUT_LO] inside {3'h2, 3'h3, 3'h5});
      if (psel && !penable) begin
         st_d.prdata = 32'h0000_0000;
         if (addr_is(paddr, `OFF_CTRL0)) st_d.prdata[7:0] = st_q.ctrl0;
         if (addr_is(paddr, `OFF_CTRL1)) st_d.prdata[7:0] = st_q.ctrl1;
         if (addr_is(paddr, `OFF_CTRL2)) st_d.prdata[7:0] = st_q.ctrl2;
         if (addr_is(paddr, `OFF_CTRL3)) st_d.prdata[7:0] = st_q.ctrl3;
         if (addr_is(paddr, `OFF_STAT_MAIN)) begin
            st_d.prdata[12:0]       = st_q.main_sw;
            st_d.prdata[`LEGAL_BIT] = st_q.main_ok;
         end
         if (addr_is(paddr, `OFF_STAT_SEC)) begin
            st_d.prdata[12:0]       = st_q.sec_sw;
            st_d.prdata[`LEGAL_BIT] = st_q.sec_ok;
         end
         if (addr_is(paddr, `OFF_STAT_MIX)) begin
            st_d.prdata[8:0]        = st_q.mix_sw;
            st_d.prdata[`LEGAL_BIT] = st_q.mix_ok;
            st_d.prdata[`SPLIT_BIT] = st_q.split;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q       <= '0;
         st_q.ctrl0 <= `RST_CTRL0;
         st_q.ctrl1 <= `RST_CTRL1;
         st_q.ctrl2 <= `RST_CTRL2;
         st_q.ctrl3 <= `RST_CTRL3;
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata         = st_q.prdata;
   assign main_switch    = st_q.main_sw;
   assign second_switch  = st_q.sec_sw;
   assign input_gain_3db = st_q.ctrl0[`GAIN_BIT];
   assign mix_switch     = st_q.mix_sw;
   assign mix_atten      = st_q.ctrl2[`ATTEN_HI:`ATTEN_LO];
   assign mix_front_en   = st_q.ctrl3[`MIX_FRONT_BIT];
   assign mix_rear_en    = st_q.ctrl3[`MIX_REAR_BIT];
   assign direct_route   = st_q.direct;
   // Pin function is one or the other by construction
   assign level_meter_en = st_q.ctrl3[`METER_BIT];
   assign offset_det_en  = ~st_q.ctrl3[`METER_BIT];

   // Short names for the assertions
   code_t cur_layout;
   code_t main_code;
   code_t mix_code;
   assign cur_layout = st_q.ctrl0[`LAYOUT_HI:`LAYOUT_LO];
   assign main_code  = st_q.ctrl0[`CODE_HI:`CODE_LO];
   assign mix_code   = st_q.ctrl2[`CODE_HI:`CODE_LO];

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_ctrl_write: assert property (acc_wr && addr_is(paddr, `OFF_CTRL0) |=>
         st_q.ctrl0 == $past(pwdata[7:0]))
      else $error("control byte 0 not written");

   a_layout0_qd1: assert property (st_q.ctrl0[7:5] == 3'h0 && st_q.ctrl0[2:0] == 3'h0 |=>
         main_switch.qd1 && $onehot(main_switch))
      else $error("layout 0 code 0 not quasi pair 1");

   a_second_se2: assert property (st_q.ctrl0[7:5] == 3'h1 && st_q.ctrl1[2:0] == 3'h4 |=>
         second_switch.se2 && $onehot(second_switch))
      else $error("second selector not single ended 2");

   a_mono_pick: assert property (st_q.ctrl0[7:5] == 3'h3 && st_q.ctrl0[2:0] == 3'h3 |=>
         main_switch.md2 == $past(st_q.ctrl0[3]) && main_switch.md1 == !$past(st_q.ctrl0[3]))
      else $error("mono pair choice wrong");

   a_unsup_silent: assert property (st_q.ctrl0[7:5] == 3'h6 && st_q.ctrl0[2:0] == 3'h0 |=>
         main_switch == '0 && !st_q.main_ok)
      else $error("unsupported code closed a switch");

   // Mix switch lags the pin function by one clock
   a_beep_gate: assert property (mix_switch.beep |-> $past(level_meter_en))
      else $error("beep mixed while detector active");

   a_beep_drop: assert property (!level_meter_en |=> !mix_switch.beep)
      else $error("beep kept after detector enabled");

   a_mix_mute: assert property (st_q.ctrl2[2:0] == `MIX_MUTE |=> mix_switch == '0)
      else $error("mix silence code passed a source");

   a_mix_l2_se5: assert property (st_q.ctrl0[7:5] == 3'h2 && st_q.ctrl2[2:0] == 3'h4 |=>
         mix_switch.se5 && $onehot(mix_switch))
      else $error("layout 2 mix code 4 not se5");

   a_direct_on: assert property ($rose(st_q.ctrl1[`DIR_REAR_BIT]) |=> direct_route.rear_qd3)
      else $error("direct rear path did not follow");

   a_pin_excl: assert property (offset_det_en != level_meter_en)
      else $error("detector and meter both or neither");

   a_layout4_full: assert property (cur_layout == 3'h4 && main_code == 3'h3 |=>
         main_switch.full_diff && $onehot(main_switch))
      else $error("layout 4 code 3 not full pair");

   a_layout7_full: assert property (cur_layout == 3'h7 && main_code == 3'h3 |=>
         main_switch.full_diff && $onehot(main_switch))
      else $error("layout 7 code 3 not full pair");

   a_layout1_se2: assert property (cur_layout == 3'h1 && main_code == 3'h4 |=>
         main_switch.se2 && $onehot(main_switch))
      else $error("layout 1 code 4 not se2");

   a_layout2_se4: assert property (cur_layout == 3'h2 && main_code == 3'h5 |=>
         main_switch.se4 && $onehot(main_switch))
      else $error("layout 2 code 5 not se4");

   a_layout2_gap: assert property (cur_layout == 3'h2 && main_code == 3'h3 |=>
         main_switch == '0)
      else $error("layout 2 code 3 closed a switch");

   a_layout3_se3: assert property (cur_layout == 3'h3 && main_code == 3'h1 |=>
         main_switch.se3 && $onehot(main_switch))
      else $error("layout 3 code 1 not se3");

   a_layout5_se5: assert property (cur_layout == 3'h5 && main_code == 3'h6 |=>
         main_switch.se5 && $onehot(main_switch))
      else $error("layout 5 code 6 not se5");

   a_layout6_md3: assert property (cur_layout == 3'h6 && main_code == 3'h7 |=>
         main_switch.md3 && $onehot(main_switch))
      else $error("layout 6 code 7 not mono 3");

   a_gain_write: assert property (acc_wr && addr_is(paddr, `OFF_CTRL0) |=>
         input_gain_3db == $past(pwdata[`GAIN_BIT]))
      else $error("input gain did not follow");

   a_direct_map: assert property (direct_route == $past(st_q.ctrl1[`DIR_SECOND_BIT:`DIR_FRONT_BIT]))
      else $error("direct paths not one clock behind");

   a_atten_write: assert property (acc_wr && addr_is(paddr, `OFF_CTRL2) |=>
         mix_atten == $past(pwdata[`ATTEN_HI:`ATTEN_LO]))
      else $error("mix attenuation did not follow");

   a_mix_l1_se2: assert property (cur_layout == 3'h1 && mix_code == 3'h1 |=>
         mix_switch.se2 && $onehot(mix_switch))
      else $error("layout 1 mix code 1 not se2");

   a_mix_l3_md2: assert property (cur_layout == 3'h3 && mix_code == 3'h5 |=>
         mix_switch.md2 && $onehot(mix_switch))
      else $error("layout 3 mix code 5 not mono 2");

   a_mix_l5_gap: assert property (cur_layout == 3'h5 && mix_code == 3'h0 |=>
         mix_switch == '0)
      else $error("layout 5 mix code 0 passed a source");

   a_mix_l6_md3: assert property (cur_layout == 3'h6 && mix_code == 3'h0 |=>
         mix_switch.md3 && $onehot(mix_switch))
      else $error("layout 6 mix code 0 not mono 3");

   c_full_diff: cover property (st_q.ctrl0[7:5] == 3'h4 ##1 main_switch.full_diff);
   c_beep_mix:  cover property (mix_switch.beep);
   c_direct:    cover property (direct_route == 3'b111);
   c_apb_err:   cover property (pslverr);

endmodule : audio_input_routing

`default_nettype wire

// file: hdl/audio_route_defs.svh
// Purpose: Offsets, field positions and reset values for the input routing decode
// Assumes: 32-bit APB, one register per aligned word, 8-bit control fields in the low byte
// Notes:   Definitions only
`ifndef AUDIO_ROUTE_DEFS_SVH
`define AUDIO_ROUTE_DEFS_SVH

// Register byte addresses
`define OFF_CTRL0      5'h00
`define OFF_CTRL1      5'h04
`define OFF_CTRL2      5'h08
`define OFF_CTRL3      5'h0C
`define OFF_STAT_MAIN  5'h10
`define OFF_STAT_SEC   5'h14
`define OFF_STAT_MIX   5'h18

// Control byte fields
`define LAYOUT_HI      7
`define LAYOUT_LO      5
`define CODE_HI        2
`define CODE_LO        0
`define MONO_BIT       3
`define GAIN_BIT       4
`define DIR_FRONT_BIT  5
`define DIR_REAR_BIT   6
`define DIR_SECOND_BIT 7
`define ATTEN_HI       7
`define ATTEN_LO       3
`define MIX_FRONT_BIT  0
`define MIX_REAR_BIT   1
`define METER_BIT      7

// Status word fields
`define LEGAL_BIT      16
`define SPLIT_BIT      17

// Mix codes common to every layout
`define MIX_BEEP       3'h6
`define MIX_MUTE       3'h7

// Reset values
`define RST_CTRL0      8'h00
`define RST_CTRL1      8'h00
`define RST_CTRL2      8'h00
`define RST_CTRL3      8'h00

`endif

// file: hdl/audio_route_pkg.sv
// Purpose: Types shared by the input routing decode
// Assumes: Nothing beyond the defs header
// Notes:   Switch enables are one bit per analog input group
package audio_route_pkg;

   typedef logic [2:0] code_t;

   typedef struct packed {
      logic md3, md2, md1, full_diff;
      logic se5, se4, se3, se2, se1;
      logic qd4, qd3, qd2, qd1;
   } src_sw_s;

   typedef struct packed {
      logic beep, md3, md2, md1;
      logic se5, se4, se3, se2, se1;
   } mix_sw_s;

   typedef struct packed {
      logic second_qd4p;
      logic rear_qd3;
      logic front_qd2;
   } direct_s;

   typedef struct packed {
      logic [7:0]  ctrl0;
      logic [7:0]  ctrl1;
      logic [7:0]  ctrl2;
      logic [7:0]  ctrl3;
      src_sw_s     main_sw;
      logic        main_ok;
      src_sw_s     sec_sw;
      logic        sec_ok;
      mix_sw_s     mix_sw;
      logic        mix_ok;
      direct_s     direct;
      logic        split;
      logic [31:0] prdata;
   } state_s;

endpackage : audio_route_pkg

// file: hdl/source_decode.sv
// Purpose: Turns an input layout and a source code into analog switch enables
// Assumes: Purely combinational; the caller registers the result
// Notes:   Unsupported codes give no enable at all
`timescale 1ns/1ps
`default_nettype none

module source_decode
   import audio_route_pkg::*;
(
   // Settings
   input  wire code_t   layout,
   input  wire code_t   code,
   input  wire logic    mono_pick,
   // Decoded
   output var  src_sw_s sw,
   output var  logic    legal
);

   always_comb begin
      sw = '0;
      unique case (layout)
         3'h0, 3'h4: begin
            case (code)
               3'h0: sw.qd1 = 1'b1;
               3'h1: sw.qd2 = 1'b1;
               3'h2: sw.qd3 = 1'b1;
               3'h3: if (layout == 3'h0) sw.qd4 = 1'b1; else sw.full_diff = 1'b1;
               default: ;
            endcase
         end
         3'h1, 3'h7: begin
            case (code)
               3'h0: sw.se1 = 1'b1;
               3'h1: sw.se3 = 1'b1;
               3'h2: sw.qd3 = 1'b1;
               3'h3: if (layout == 3'h1) sw.qd4 = 1'b1; else sw.full_diff = 1'b1;
               3'h4: sw.se2 = 1'b1;
               default: ;
            endcase
         end
         3'h2: begin
            case (code)
               3'h0: sw.se1 = 1'b1;
               3'h1: sw.se3 = 1'b1;
               3'h2: sw.qd3 = 1'b1;
               3'h4: sw.se2 = 1'b1;
               3'h5: sw.se4 = 1'b1;
               3'h6: sw.se5 = 1'b1;
               default: ;
            endcase
         end
         3'h3: begin
            case (code)
               3'h0: sw.se1 = 1'b1;
               3'h1: sw.se3 = 1'b1;
               3'h2: sw.qd3 = 1'b1;
               3'h3: if (mono_pick) sw.md2 = 1'b1; else sw.md1 = 1'b1;
               3'h4: sw.se2 = 1'b1;
               default: ;
            endcase
         end
         3'h5: begin
            case (code)
               3'h0: sw.qd1 = 1'b1;
               3'h1: sw.qd2 = 1'b1;
               3'h2: sw.qd3 = 1'b1;
               3'h5: sw.se4 = 1'b1;
               3'h6: sw.se5 = 1'b1;
               default: ;
            endcase
         end
         3'h6: begin
            case (code)
               3'h1: sw.se3 = 1'b1;
               3'h2: sw.qd3 = 1'b1;
               3'h3: sw.full_diff = 1'b1;
               3'h4: sw.se2 = 1'b1;
               3'h7: sw.md3 = 1'b1;
               default: ;
            endcase
         end
      endcase
      // Unsupported codes fall through with every switch open
      legal = |sw;
   end

endmodule : source_decode

`default_nettype wire

// file: tb/ctrl_host.sv
// Purpose: Control host that writes and reads the routing registers over APB
// Assumes: Slave may stretch the access phase; a bounded wait ends a hang
// Notes:   Released lines carry inverted data so stale values never look valid
`timescale 1ns/1ps
`default_nettype none

module ctrl_host #(
   parameter int ADDR_W = 12
)(
   // Clock
   input  wire logic              pclk,
   // APB master
   output var  logic              psel,
   output var  logic              penable,
   output var  logic              pwrite,
   output var  logic [ADDR_W-1:0] paddr,
   output var  logic [31:0]       pwdata,
   output var  logic [3:0]        pstrb,
   input  wire logic [31:0]       prdata,
   input  wire logic              pready,
   input  wire logic              pslverr
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = '0;
      pwdata  = '0;
      pstrb   = 4'h0;
   end

   // Codes pass through as given; callers keep to supported ones except on purpose
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err, output logic hung);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= 4'hF;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      hung    = (pready !== 1'b1);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~d;
      pstrb   <= 4'h0;
   endtask : xfer
endmodule : ctrl_host

`default_nettype wire

// file: tb/test_audio_input_routing.sv
// Purpose: Self-checking bench for the input routing decode
// Assumes: Zero-wait APB slave, decoded outputs one clock behind the registers
// Notes:   Table rows hold one hex digit per code: switch bit index, F for none
`timescale 1ns/1ps
`default_nettype none
`include "audio_route_defs.svh"

module test_audio_input_routing;
   import audio_route_pkg::*;
   localparam int ADDR_W = 12;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata;
   logic [3:0]        pstrb;
   src_sw_s           main_switch, second_switch;
   mix_sw_s           mix_switch;
   direct_s           direct_route;
   logic              input_gain_3db, mix_front_en, mix_rear_en, offset_det_en, level_meter_en;
   logic [4:0]        mix_atten;
   int                fail_count, check_count;
   logic [31:0]       src_rows [8];
   logic [31:0]       mix_rows [8];

   audio_input_routing #(.ADDR_W(ADDR_W)) audio_input_routing_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .main_switch(main_switch),
      .second_switch(second_switch), .input_gain_3db(input_gain_3db), .mix_switch(mix_switch),
      .mix_atten(mix_atten), .mix_front_en(mix_front_en), .mix_rear_en(mix_rear_en),
      .direct_route(direct_route), .offset_det_en(offset_det_en), .level_meter_en(level_meter_en));

   ctrl_host #(.ADDR_W(ADDR_W)) ctrl_host_inst (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic bus(input logic wr, input logic [4:0] off, input logic [7:0] d,
                      output logic [31:0] rd, output logic err);
      logic hung;
      ctrl_host_inst.xfer(wr, {{(ADDR_W-5){1'b0}}, off}, {24'h0, d}, rd, err, hung);
      if (hung) begin
         fail_count++;
         $display("MISMATCH t=%0t no pready", $time);
         complete_run();
      end
   endtask : bus

   task automatic wreg(input logic [4:0] off, input logic [7:0] d);
      logic [31:0] rd;
      logic        err;
      bus(1'b1, off, d, rd, err);
   endtask : wreg

   // Register loads at the last edge, outputs one edge later
   task automatic settle();
      repeat (2) @(posedge pclk);
      #1;
   endtask : settle

   function automatic logic [12:0] one_hot(input logic [3:0] i);
      return (i == 4'hF) ? 13'h0 : 13'h1 << i;
   endfunction : one_hot

   initial begin
      logic [31:0] rd;
      logic        err;
      logic [3:0]  si, mi;
      fail_count  = 0;
      check_count = 0;
      presetn     = 1'b0;
      // Source index: qd1-4 0-3, se1-5 4-8, fd 9, md1-3 A-C
      src_rows = '{32'hFFFF_3210, 32'hFFF5_3264, 32'hF875_F264, 32'hFFF5_A264,
                   32'hFFFF_9210, 32'hF87F_F210, 32'hCFF5_926F, 32'hFFF5_9264};
      // Mix index: se1-5 0-4, md1-3 5-7, beep 8; silence is no switch
      mix_rows = '{32'hF8FF_FFFF, 32'hF8FF_F210, 32'hF8F4_3210, 32'hF86F_5210,
                   32'hF8FF_FFFF, 32'hF8F4_3FFF, 32'hF8FF_F217, 32'hF8FF_F210};
      @(posedge pclk);
      #1;
      check({19'h0, main_switch}, 32'h0, "reset main");
      check({30'h0, offset_det_en, level_meter_en}, 32'h2, "reset pin function");
      @(posedge pclk);
      presetn <= 1'b1;
      settle();
      check({19'h0, main_switch}, 32'h1, "first main");
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, 5'(4 * i), 8'h00, rd, err);
         check(rd, 32'h0, "reset ctrl");
      end
      $display("Test reset done");

      wreg(`OFF_CTRL3, 8'h80);
      for (int l = 0; l < 8; l++) begin
         for (int c = 0; c < 8; c++) begin
            wreg(`OFF_CTRL0, {l[2:0], c[0], 1'b0, c[2:0]});
            wreg(`OFF_CTRL1, {5'h00, c[2:0]});
            wreg(`OFF_CTRL2, {l[2:0], c[1:0], c[2:0]});
            settle();
            si = src_rows[l][4*c +: 4];
            mi = mix_rows[l][4*c +: 4];
            check({19'h0, main_switch}, {19'h0, one_hot(si)}, "main");
            check({19'h0, second_switch}, {19'h0, one_hot(si)}, "second");
            check({23'h0, mix_switch}, {23'h0, one_hot(mi)}, "mix");
            check({27'h0, mix_atten}, {27'h0, l[2:0], c[1:0]}, "atten");
            check({31'h0, input_gain_3db}, {31'h0, c[0]}, "gain");
         end
      end
      $display("Test table done");

      wreg(`OFF_CTRL0, 8'h6B);
      wreg(`OFF_CTRL1, 8'h03);
      settle();
      check({19'h0, main_switch}, 32'h800, "mono second pair");
      check({19'h0, second_switch}, 32'h400, "mono first pair");
      wreg(`OFF_CTRL1, 8'h83);
      settle();
      bus(1'b0, `OFF_STAT_MAIN, 8'h00, rd, err);
      check(rd, 32'h0001_0800, "main status");
      bus(1'b0, `OFF_STAT_MIX, 8'h00, rd, err);
      check(rd, 32'h0003_0000, "mix status");
      wreg(`OFF_CTRL0, 8'h43);
      settle();
      bus(1'b0, `OFF_STAT_SEC, 8'h00, rd, err);
      check(rd, 32'h0, "second status");
      check({19'h0, main_switch}, 32'h0, "layout 2 gap");
      $display("Test mono choice done");

      wreg(`OFF_CTRL0, 8'h00);
      wreg(`OFF_CTRL2, 8'hFE);
      wreg(`OFF_CTRL3, 8'h00);
      settle();
      check({23'h0, mix_switch}, 32'h0, "beep blocked");
      check({30'h0, offset_det_en, level_meter_en}, 32'h2, "detector on");
      for (int v = 1; v < 4; v++) begin
         wreg(`OFF_CTRL3, {6'h20, v[1:0]});
         settle();
         check({23'h0, mix_switch}, 32'h100, "beep offered");
         check({30'h0, offset_det_en, level_meter_en}, 32'h1, "meter on");
         check({30'h0, mix_rear_en, mix_front_en}, {30'h0, v[1:0]}, "mix targets");
         check({27'h0, mix_atten}, 32'h1F, "atten max");
      end
      $display("Test mixer done");

      // Layout 0 keeps both second outputs on one source
      for (int i = 0; i < 8; i++) begin
         wreg(`OFF_CTRL1, {i[2:0], 5'h00});
         settle();
         check({29'h0, direct_route}, {29'h0, i[2:0]}, "direct");
      end
      bus(1'b0, `OFF_CTRL1, 8'h00, rd, err);
      check(rd, 32'hE0, "readback");
      check({31'h0, err}, 32'h0, "readback err");
      bus(1'b0, 5'h1C, 8'h00, rd, err);
      check({31'h0, err}, 32'h1, "unmapped err");
      check(rd, 32'h0, "unmapped data");
      $display("Test direct and bus done");

      @(posedge pclk);
      presetn <= 1'b0;
      #1;
      check({29'h0, direct_route}, 32'h0, "midrun reset direct");
      check({30'h0, offset_det_en, level_meter_en}, 32'h2, "midrun reset pin");
      @(posedge pclk);
      presetn <= 1'b1;
      settle();
      bus(1'b0, `OFF_CTRL1, 8'h00, rd, err);
      check(rd, 32'h0, "ctrl after reset");
      check({19'h0, main_switch}, 32'h1, "main after reset");
      $display("Test midrun reset done");
      complete_run();
   end
endmodule : test_audio_input_routing

`default_nettype wire
